// File: logic/epb_bank.sv
// Encoder position object bank: parameters, position, speed and timer.
//
// Overview of operation
// RULE1 - Operating bit 0 picks count direction: 0 clockwise up, 1 CCW up.
// RULE2 - Operating bit 2 set enables scaling; clear gives the native count.
// RULE3 - Scaled position uses steps per revolution and the total range.
// RULE4 - Vendor, measure direction, diagnostic bits absent; 11..4 reserved.
// RULE5 - Direction bit storage shared with manufacturer direction object.
// RULE6 - Steps per revolution shared with manufacturer resolution object.
// RULE7 - Writable 32-bit total range parameter held by the device.
// RULE8 - Writable 32-bit preset, default zero, sets the output position.
// RULE9 - Position value read-only, mappable, same as manufacturer position.
// RULE10 - Read-only 64-bit high-resolution position is provided.
// RULE11 - High-resolution position ignores both total range settings.
// RULE12 - High-resolution position applies the steps per revolution.
// RULE13 - Preset write also loads the high-resolution position, 32-bit range.
// RULE14 - 16-bit speed saturates at its limits instead of wrapping.
// RULE15 - A 32-bit speed object gives unsaturated speed.
// RULE16 - Read-only 16-bit signed acceleration for channel 1.
// RULE17 - Cyclic timer in ms, default 64h; master writes only legal values.
// RULE18 - Cyclic timer shared with TPDO1 event timer and cycle-time object.
// RULE19 - Cam state per channel from subindex 1; channel 1 defaults 4h.
// RULE20 - Writable 8-bit cam enable for channel 1 selects active cams.
// RULE21 - Output is scaled count plus preset offset, wrapped in total range.
// RULE22 - Reserved and absent operating bits ignore writes and read zero.
`timescale 1ns/1ps
`include "epb_regs.svh"

module epb_bank
  import epb_pkg::*;
#(
  parameter logic [31:0] P_SPR_DEFAULT   = `EPB_NATIVE_SPR,
  parameter logic [31:0] P_TOTAL_DEFAULT = `EPB_RST_TOTAL,
  parameter int          P_CYC_PER_MS    = `EPB_MS_NS / `EPB_CLK_NS
) (
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  input  wire epb_req_t    i_req,
  output epb_rsp_t         o_rsp,
  input  wire logic        i_sample,
  input  wire epb_raw_t    i_raw,
  input  wire logic [31:0] i_speed,
  input  wire logic [15:0] i_accel,
  input  wire logic [7:0]  i_cam_hits,
  output logic [31:0]      o_position,
  output logic [63:0]      o_hr_position,
  output logic [15:0]      o_speed,
  output logic [7:0]       o_cam_state,
  output logic             o_tx_tick
);

  // ****************************************************************
  // Object decode
  // ****************************************************************

  // True when the request names the given index and subindex.
  function automatic logic hit(input epb_req_t r, input logic [15:0] idx,
                               input logic [7:0] sub);
    hit = (r.index == idx) && (r.sub == sub);
  endfunction

  logic        dir_ff;
  logic        scale_ff;
  logic [31:0] spr_ff;
  logic [31:0] total_ff;
  logic [31:0] preset_ff;
  logic [63:0] offset_ff;
  logic [31:0] pos_ff;
  logic [63:0] hr_ff;
  logic [15:0] spd16_ff;
  logic [31:0] spd32_ff;
  logic [15:0] acc_ff;
  logic [15:0] cyc_ff;
  logic [7:0]  camst_ff;
  logic [7:0]  camen_ff;
  epb_rsp_t    rsp_ff;
  logic [31:0] ms_cnt_ff;
  logic [15:0] per_cnt_ff;
  logic        tick_ff;

  // Reset image of the operating word; a literal cannot be bit-selected,
  // so the word is held as a constant and its kept bits picked from it.
  localparam logic [15:0] OPER_RST = `EPB_RST_OPER;

  // Writable objects; each alias group lands on one register.
  wire logic w_oper   = i_req.wr && (hit(i_req, `EPB_OD_OPER, `EPB_SUB_0) ||
                        hit(i_req, `EPB_OD_M_DIR, `EPB_SUB_0));
  wire logic w_spr    = i_req.wr && (hit(i_req, `EPB_OD_SPR, `EPB_SUB_0) ||
                        hit(i_req, `EPB_OD_M_SPR, `EPB_SUB_0)); // RULE6
  wire logic w_total  = i_req.wr && (hit(i_req, `EPB_OD_TOTAL, `EPB_SUB_0) ||
                        hit(i_req, `EPB_OD_M_TOTAL, `EPB_SUB_0)); // RULE7
  wire logic w_preset = i_req.wr && (hit(i_req, `EPB_OD_PRESET, `EPB_SUB_0) ||
                        hit(i_req, `EPB_OD_M_PRESET, `EPB_SUB_0)); // RULE8
  wire logic w_cyc    = i_req.wr && (hit(i_req, `EPB_OD_CYC, `EPB_SUB_0) ||
                        hit(i_req, `EPB_OD_M_CYC, `EPB_SUB_0) ||
                        hit(i_req, `EPB_OD_TPDO1, `EPB_SUB_EVT)); // RULE18
  wire logic w_camen  = i_req.wr && hit(i_req, `EPB_OD_CAMEN, `EPB_SUB_CH1);
  wire logic wr_ok    = w_oper | w_spr | w_total | w_preset | w_cyc | w_camen;

  // ****************************************************************
  // Position arithmetic
  // ****************************************************************

  // Counter-clockwise counting negates the whole native count.
  wire logic [46:0] raw_w = i_raw;
  wire logic [46:0] nat_w = dir_ff ? (47'(0) - raw_w) : raw_w; // RULE1
  // Scaling off means the native 16-bit step grid per turn.
  wire logic [31:0] spr_eff = scale_ff ? spr_ff : `EPB_NATIVE_SPR; // RULE2
  wire logic [62:0] mt_prod = 63'(nat_w[46:16]) * 63'(spr_eff); // RULE12
  wire logic [47:0] st_prod = 48'(nat_w[15:0]) * 48'(spr_eff);
  wire logic [63:0] scaled_w = 64'(mt_prod) + 64'(st_prod[47:16]); // RULE3
  // The wide value never wraps at the total range, so it stays unbounded.
  wire logic [63:0] hr_w = scaled_w + offset_ff; // RULE11
  wire logic        wrap_on = scale_ff && (total_ff != 32'h0000_0000);
  // A zero range would divide by zero, so it is treated as no wrap.
  wire logic [63:0] mod_w = hr_w % 64'(total_ff);
  wire logic [31:0] pos_w = wrap_on ? mod_w[31:0] : hr_w[31:0]; // RULE21

  // Speed follows the count direction and is clamped to 16 bits.
  wire logic [31:0] spd_w = dir_ff ? (32'(0) - i_speed) : i_speed;
  wire logic        sp_hi = !spd_w[31] && (spd_w[30:15] != 16'h0000);
  wire logic        sp_lo = spd_w[31] && (spd_w[30:15] != 16'hFFFF);
  wire logic [15:0] spd_sat = sp_hi ? 16'h7FFF :
                              sp_lo ? 16'h8000 : spd_w[15:0]; // RULE14

  // ****************************************************************
  // Read multiplexer
  // ****************************************************************

  // Reserved and absent operating bits are never stored, so read zero.
  wire logic [15:0] oper_rd = 16'(({15'h0000, scale_ff} << `EPB_BIT_SCALE) |
                              ({15'h0000, dir_ff} << `EPB_BIT_DIR)); // RULE22
  logic [63:0] rd_data;
  logic        rd_ok;
  always_comb begin
    rd_ok = 1'b1;
    rd_data = 64'h0000_0000_0000_0000;
    if (hit(i_req, `EPB_OD_OPER, `EPB_SUB_0) ||
        hit(i_req, `EPB_OD_M_DIR, `EPB_SUB_0)) begin
      rd_data = 64'(oper_rd); // RULE5
    end else if (hit(i_req, `EPB_OD_SPR, `EPB_SUB_0) ||
                 hit(i_req, `EPB_OD_M_SPR, `EPB_SUB_0)) begin
      rd_data = 64'(spr_ff);
    end else if (hit(i_req, `EPB_OD_TOTAL, `EPB_SUB_0) ||
                 hit(i_req, `EPB_OD_M_TOTAL, `EPB_SUB_0)) begin
      rd_data = 64'(total_ff);
    end else if (hit(i_req, `EPB_OD_PRESET, `EPB_SUB_0) ||
                 hit(i_req, `EPB_OD_M_PRESET, `EPB_SUB_0)) begin
      rd_data = 64'(preset_ff);
    end else if (hit(i_req, `EPB_OD_POS, `EPB_SUB_0) ||
                 hit(i_req, `EPB_OD_M_POS, `EPB_SUB_0)) begin
      rd_data = 64'(pos_ff); // RULE9
    end else if (hit(i_req, `EPB_OD_HRPOS, `EPB_SUB_0)) begin
      rd_data = hr_ff; // RULE10
    end else if (hit(i_req, `EPB_OD_SPEED, `EPB_SUB_CH1)) begin
      rd_data = 64'(spd16_ff);
    end else if (hit(i_req, `EPB_OD_SPEED32, `EPB_SUB_0)) begin
      rd_data = 64'(spd32_ff); // RULE15
    end else if (hit(i_req, `EPB_OD_ACCEL, `EPB_SUB_CH1)) begin
      rd_data = 64'(acc_ff); // RULE16
    end else if (hit(i_req, `EPB_OD_CYC, `EPB_SUB_0) ||
                 hit(i_req, `EPB_OD_M_CYC, `EPB_SUB_0) ||
                 hit(i_req, `EPB_OD_TPDO1, `EPB_SUB_EVT)) begin
      rd_data = 64'(cyc_ff);
    end else if (hit(i_req, `EPB_OD_CAMST, `EPB_SUB_CH1)) begin
      rd_data = 64'(camst_ff); // RULE19
    end else if (hit(i_req, `EPB_OD_CAMEN, `EPB_SUB_CH1)) begin
      rd_data = 64'(camen_ff); // RULE20
    end else if (hit(i_req, `EPB_OD_SPEED, `EPB_SUB_0) ||
                 hit(i_req, `EPB_OD_ACCEL, `EPB_SUB_0) ||
                 hit(i_req, `EPB_OD_CAMST, `EPB_SUB_0) ||
                 hit(i_req, `EPB_OD_CAMEN, `EPB_SUB_0)) begin
      rd_data = 64'(`EPB_NUM_SUB);
    end else begin
      rd_ok = 1'b0;
    end
  end

  // ****************************************************************
  // Parameter storage
  // ****************************************************************

  // Only the direction and scaling bits are kept from a word write.
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dir_ff    <= OPER_RST[`EPB_BIT_DIR];
      scale_ff  <= OPER_RST[`EPB_BIT_SCALE];
      spr_ff    <= P_SPR_DEFAULT;
      total_ff  <= P_TOTAL_DEFAULT;
      preset_ff <= `EPB_RST_PRESET;
      cyc_ff    <= `EPB_RST_CYC;
      camen_ff  <= `EPB_RST_CAMEN;
    end else begin
      if (w_oper) begin
        dir_ff   <= i_req.wdata[`EPB_BIT_DIR]; // RULE5
        scale_ff <= i_req.wdata[`EPB_BIT_SCALE]; // RULE4
      end
      if (w_spr) begin
        spr_ff <= i_req.wdata; // RULE6
      end
      if (w_total) begin
        total_ff <= i_req.wdata; // RULE7
      end
      if (w_preset) begin
        preset_ff <= i_req.wdata; // RULE8
      end
      if (w_cyc) begin
        cyc_ff <= i_req.wdata[15:0]; // RULE17
      end
      if (w_camen) begin
        camen_ff <= i_req.wdata[7:0]; // RULE20
      end
    end
  end

  // ****************************************************************
  // Process values
  // ****************************************************************

  // A preset wins over a sample taken in the same cycle, so the value
  // written is what the master sees first.
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      offset_ff <= 64'h0000_0000_0000_0000;
      pos_ff    <= 32'h0000_0000;
      hr_ff     <= 64'h0000_0000_0000_0000;
      spd16_ff  <= 16'h0000;
      spd32_ff  <= 32'h0000_0000;
      acc_ff    <= 16'h0000;
      camst_ff  <= `EPB_RST_CAMST;
    end else begin
      if (w_preset) begin
        offset_ff <= 64'(i_req.wdata) - scaled_w; // RULE21
        pos_ff    <= i_req.wdata;
        hr_ff     <= 64'(i_req.wdata); // RULE13
      end else if (i_sample) begin
        pos_ff <= pos_w;
        hr_ff  <= hr_w;
      end
      if (i_sample) begin
        spd16_ff <= spd_sat; // RULE14
        spd32_ff <= spd_w; // RULE15
        acc_ff   <= i_accel; // RULE16
        camst_ff <= i_cam_hits & camen_ff; // RULE19
      end
    end
  end

  // ****************************************************************
  // Cyclic transmit timer and request answer
  // ****************************************************************

  // Period zero is outside the legal range and simply stops the tick.
  wire logic ms_end = (ms_cnt_ff == 32'(P_CYC_PER_MS - 1));
  wire logic per_end = ms_end && (per_cnt_ff == cyc_ff - 16'h0001);
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ms_cnt_ff  <= 32'h0000_0000;
      per_cnt_ff <= 16'h0000;
      tick_ff    <= 1'b0;
    end else begin
      ms_cnt_ff  <= ms_end ? 32'h0000_0000 : ms_cnt_ff + 32'h0000_0001;
      per_cnt_ff <= (cyc_ff == 16'h0000 || per_end) ? 16'h0000 :
                    per_cnt_ff + 16'(ms_end);
      tick_ff    <= per_end && (cyc_ff != 16'h0000); // RULE18
    end
  end

  // Every request is answered exactly one clock later.
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rsp_ff <= '0;
    end else begin
      rsp_ff.ack   <= i_req.wr | i_req.rd;
      rsp_ff.abort <= (i_req.wr && !wr_ok) || (i_req.rd && !rd_ok);
      rsp_ff.rdata <= i_req.rd ? rd_data : rsp_ff.rdata;
    end
  end

  assign o_rsp         = rsp_ff;
  assign o_position    = pos_ff;
  assign o_hr_position = hr_ff;
  assign o_speed       = spd16_ff;
  assign o_cam_state   = camst_ff;
  assign o_tx_tick     = tick_ff;

  // ****************************************************************
  // Checks
  // ****************************************************************

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  sequence s_dir_wr;
    i_req.wr && hit(i_req, `EPB_OD_M_DIR, `EPB_SUB_0);
  endsequence
  sequence s_oper_rd;
    i_req.rd && !i_req.wr && hit(i_req, `EPB_OD_OPER, `EPB_SUB_0);
  endsequence

  chk_dir_shared: assert property (s_dir_wr ##2 s_oper_rd |=> // RULE5
      o_rsp.rdata[0] == $past(i_req.wdata[0], 3))
    else $error("direction bit not shared");
  chk_oper_clean: assert property (s_oper_rd |=> // RULE22
      o_rsp.ack && o_rsp.rdata[63:3] == '0 && !o_rsp.rdata[1])
    else $error("unused operating bits read nonzero");
  chk_preset_hr: assert property (w_preset |=> // RULE13
      hr_ff == 64'($past(i_req.wdata)) && pos_ff == $past(i_req.wdata))
    else $error("preset not loaded");
  chk_speed_sat: assert property (i_sample |=> // RULE14
      ($signed(spd32_ff) >= 32'sd32767) == (spd16_ff == 16'h7FFF))
    else $error("speed not saturated");
  chk_pos_ro: assert property (i_req.wr && // RULE9
      hit(i_req, `EPB_OD_POS, `EPB_SUB_0) |=> o_rsp.abort)
    else $error("position write not refused");
  chk_pos_read: assert property (i_req.rd && // RULE9
      hit(i_req, `EPB_OD_M_POS, `EPB_SUB_0) |=>
      o_rsp.rdata == 64'($past(pos_ff)))
    else $error("position mirror differs");
  chk_timer_share: assert property (i_req.wr && // RULE18
      hit(i_req, `EPB_OD_TPDO1, `EPB_SUB_EVT) |=>
      cyc_ff == $past(i_req.wdata[15:0]))
    else $error("event timer not shared");
  chk_spr_native: assert property (!scale_ff && i_sample && !w_preset // RULE2
      |=> hr_ff == $past(64'(nat_w)) + $past(offset_ff))
    else $error("unscaled position wrong");
  chk_cam_reset: assert property ($rose(i_rst_n) |-> // RULE19
      camst_ff == 8'h04)
    else $error("cam state default wrong");

  // Negative clamp, cam masking and pass-through, checked where each
  // sample lands; a refusal must always come with its acknowledge.
  chk_speed_low: assert property (i_sample |=> // RULE14
      ($signed(spd32_ff) <= -32'sd32768) == (spd16_ff == 16'h8000))
    else $error("speed not clamped low");
  chk_cam_mask: assert property (i_sample |=> // RULE20
      (camst_ff & ~$past(camen_ff)) == 8'h00)
    else $error("disabled cam reported");
  chk_acc_pass: assert property (i_sample |=> // RULE16
      acc_ff == $past(i_accel))
    else $error("acceleration not captured");
  chk_abort_ack: assert property (o_rsp.abort |-> o_rsp.ack) // RULE9
    else $error("abort without acknowledge");

endmodule

// File: logic/epb_pkg.sv
// Types shared by the encoder position object bank.
package epb_pkg;

  // Object dictionary access request from the protocol engine.
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] index;
    logic [7:0]  sub;
    logic [31:0] wdata;
  } epb_req_t;

  // Answer to a request, one clock after it is taken.
  typedef struct packed {
    logic        ack;
    logic        abort;
    logic [63:0] rdata;
  } epb_rsp_t;

  // Native sensor sample: whole turns and step within the turn.
  typedef struct packed {
    logic [30:0] turns;
    logic [15:0] step;
  } epb_raw_t;

endpackage

// File: logic/epb_regs.svh
// Object indices, field positions, reset values and timing of the bank.
`ifndef EPB_REGS_SVH
`define EPB_REGS_SVH

// ****************************************************************
// Application profile object indices
// ****************************************************************
`define EPB_OD_OPER     16'h6000
`define EPB_OD_SPR      16'h6001
`define EPB_OD_TOTAL    16'h6002
`define EPB_OD_PRESET   16'h6003
`define EPB_OD_POS      16'h6004
`define EPB_OD_HRPOS    16'h6008
`define EPB_OD_SPEED    16'h6030
`define EPB_OD_ACCEL    16'h6040
`define EPB_OD_CYC      16'h6200
`define EPB_OD_CAMST    16'h6300
`define EPB_OD_CAMEN    16'h6301

// ****************************************************************
// Manufacturer and communication objects; all but the 32-bit speed share storage
// ****************************************************************
`define EPB_OD_M_POS    16'h2000
`define EPB_OD_M_DIR    16'h2100
`define EPB_OD_M_SPR    16'h2101
`define EPB_OD_M_TOTAL  16'h2102
`define EPB_OD_M_PRESET 16'h2103
`define EPB_OD_M_CYC    16'h2200
`define EPB_OD_TPDO1    16'h1800
`define EPB_OD_SPEED32  16'h3010
`define EPB_SUB_EVT     8'h05
`define EPB_SUB_0       8'h00
`define EPB_SUB_CH1     8'h01
`define EPB_NUM_SUB     8'h01

// ****************************************************************
// Operating parameter fields and reset values
// ****************************************************************
`define EPB_BIT_DIR     0
`define EPB_BIT_SCALE   2
`define EPB_RST_OPER    16'h0000
`define EPB_RST_PRESET  32'h0000_0000
`define EPB_RST_CYC     16'h0064
`define EPB_RST_CAMST   8'h04
`define EPB_RST_CAMEN   8'h00
`define EPB_NATIVE_SPR  32'h0001_0000
`define EPB_RST_TOTAL   32'h4000_0000

// ****************************************************************
// Timing
// ****************************************************************
`define EPB_MS_NS       1000000
`define EPB_CLK_NS      4

`endif

// File: testbench/epb_bank_tb_top.sv
// Self-checking testbench of the encoder position object bank.
`timescale 1ns/1ps
`include "epb_regs.svh"
`define TB_CHK(got, exp) begin \
  n_checks++; \
  if ((got) !== (exp)) begin \
    failures++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); \
  end \
end

module epb_bank_tb_top;
  import epb_pkg::*;

  // ****************************************************************
  // Signals and bookkeeping
  // ****************************************************************
  typedef struct packed {
    logic        abort;
    logic        use_data;
    logic [63:0] data;
  } epb_note_t;

  localparam int CYC_MS = 4;
  logic        i_mclk = 1'b0;
  logic        i_rst_n = 1'b0;
  epb_req_t    req;
  epb_rsp_t    rsp;
  logic        smp = 1'b0;
  epb_raw_t    raw = '0;
  logic [31:0] spd = '0;
  logic [15:0] acc = '0;
  logic [7:0]  cams = '0;
  logic [31:0] o_position;
  logic [63:0] o_hr_position;
  logic [15:0] o_speed;
  logic [7:0]  o_cam_state;
  logic        o_tx_tick;
  epb_note_t   notes[$];
  epb_note_t   note;
  int          failures = 0;
  int          n_checks = 0;
  int          cycles = 0;
  logic [30:0] t;
  logic [15:0] s;
  logic [7:0]  en;
  logic [7:0]  c;
  logic [31:0] sp_in[3] = '{32'h0001_2345, 32'hFFFE_0000, 32'h0000_1234};
  logic [15:0] sp_sat[3] = '{16'h7FFF, 16'h8000, 16'h1234};
  int unsigned seed_v;

  always #2 i_mclk = ~i_mclk;

  epb_master_model mst_u (.i_mclk(i_mclk), .o_req(req));

  epb_bank #(.P_CYC_PER_MS(CYC_MS)) dut_u (
    .i_mclk       (i_mclk),
    .i_rst_n      (i_rst_n),
    .i_req        (req),
    .o_rsp        (rsp),
    .i_sample     (smp),
    .i_raw        (raw),
    .i_speed      (spd),
    .i_accel      (acc),
    .i_cam_hits   (cams),
    .o_position   (o_position),
    .o_hr_position(o_hr_position),
    .o_speed      (o_speed),
    .o_cam_state  (o_cam_state),
    .o_tx_tick    (o_tx_tick)
  );

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic stop_test();
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Each access notes its expected answer before the request leaves.
  task automatic rd(input logic [15:0] i, input logic [7:0] sb,
                    input logic [63:0] e);
    notes.push_back('{1'b0, 1'b1, e});
    mst_u.access(1'b0, 1'b1, i, sb, 32'h0000_0000);
  endtask

  task automatic wr(input logic [15:0] i, input logic [7:0] sb,
                    input logic [31:0] d, input logic ab);
    notes.push_back('{ab, 1'b0, 64'h0});
    mst_u.access(1'b1, 1'b0, i, sb, d);
  endtask

  // Sensor sample; returns once the registered outputs have settled.
  task automatic sample(input logic [30:0] tt, input logic [15:0] ss,
                        input logic [31:0] v, input logic [7:0] ch);
    @(posedge i_mclk);
    smp <= 1'b1;
    raw <= '{turns: tt, step: ss};
    spd <= v;
    acc <= 16'h8123;
    cams <= ch;
    @(posedge i_mclk);
    smp <= 1'b0;
    @(posedge i_mclk);
    @(negedge i_mclk);
  endtask

  // Cycles between ticks; only the third gap is checked, as the first is partial.
  task automatic tick_gap(input int e);
    int n;
    n = 0;
    for (int k = 0; k < 3; k++) begin
      n = 0;
      do begin
        @(negedge i_mclk);
        n++;
      end while (o_tx_tick !== 1'b1 && n < 1000);
    end
    `TB_CHK(n, e)
  endtask

  // ****************************************************************
  // Answer monitor and hang guard
  // ****************************************************************
  // Sampled at the falling edge, where the one-cycle ack is settled.
  always @(negedge i_mclk) begin
    if (rsp.ack === 1'b1) begin
      if (notes.size() == 0) begin
        `TB_CHK(rsp.ack, 1'b0)
      end else begin
        note = notes.pop_front();
        `TB_CHK(rsp.abort, note.abort)
        if (note.use_data) `TB_CHK(rsp.rdata, note.data)
      end
    end
  end

  // The whole run needs about 1250 cycles; 6000 leaves ample margin.
  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 6000) begin
      failures++;
      stop_test();
    end
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    seed_v = $urandom(32'h1244e7a6);
    repeat (20) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    rd(`EPB_OD_OPER, 8'h00, 64'h0);
    rd(`EPB_OD_PRESET, 8'h00, 64'h0);
    rd(`EPB_OD_CYC, 8'h00, 64'h64);
    rd(`EPB_OD_CAMST, 8'h01, 64'h4);
    rd(`EPB_OD_SPR, 8'h00, 64'h1_0000);
    rd(`EPB_OD_TOTAL, 8'h00, 64'h4000_0000);
    rd(`EPB_OD_CAMEN, 8'h01, 64'h0);
    $display("test reset_values done");
    wr(`EPB_OD_OPER, 8'h00, 32'h0000_FFFF, 1'b0);
    rd(`EPB_OD_OPER, 8'h00, 64'h5);
    rd(`EPB_OD_M_DIR, 8'h00, 64'h5);
    wr(`EPB_OD_M_DIR, 8'h00, 32'h0000_0000, 1'b0);
    rd(`EPB_OD_OPER, 8'h00, 64'h0);
    wr(`EPB_OD_POS, 8'h00, 32'h0000_0001, 1'b1);
    wr(`EPB_OD_HRPOS, 8'h00, 32'h0000_0001, 1'b1);
    $display("test operating_bits done");
    // Unscaled native count with random turns and steps.
    for (int k = 0; k < 8; k++) begin
      t = 31'($urandom);
      s = 16'($urandom);
      sample(t, s, 32'h0, 8'h00);
      rd(`EPB_OD_POS, 8'h00, {32'h0, t[15:0], s});
      rd(`EPB_OD_M_POS, 8'h00, {32'h0, t[15:0], s});
      rd(`EPB_OD_HRPOS, 8'h00, {17'h0, t, s});
    end
    $display("test native_position done");
    wr(`EPB_OD_OPER, 8'h00, 32'h0000_0001, 1'b0);
    sample(31'h3, 16'h8000, 32'h0, 8'h00);
    `TB_CHK(o_position, 32'hFFFC_8000)
    `TB_CHK(o_hr_position, 64'h0000_7FFF_FFFC_8000)
    rd(`EPB_OD_HRPOS, 8'h00, 64'h0000_7FFF_FFFC_8000);
    $display("test direction done");
    wr(`EPB_OD_OPER, 8'h00, 32'h0000_0004, 1'b0);
    wr(`EPB_OD_SPR, 8'h00, 32'h0000_1000, 1'b0);
    wr(`EPB_OD_TOTAL, 8'h00, 32'h0000_5000, 1'b0);
    sample(31'h7, 16'h8000, 32'h0, 8'h00);
    rd(`EPB_OD_POS, 8'h00, 64'h2800);
    rd(`EPB_OD_HRPOS, 8'h00, 64'h7800);
    rd(`EPB_OD_M_SPR, 8'h00, 64'h1000);
    wr(`EPB_OD_M_SPR, 8'h00, 32'h0000_2000, 1'b0);
    sample(31'h7, 16'h8000, 32'h0, 8'h00);
    rd(`EPB_OD_HRPOS, 8'h00, 64'hF000);
    rd(`EPB_OD_POS, 8'h00, 64'h0);
    wr(`EPB_OD_PRESET, 8'h00, 32'h0000_0100, 1'b0);
    rd(`EPB_OD_POS, 8'h00, 64'h100);
    rd(`EPB_OD_HRPOS, 8'h00, 64'h100);
    sample(31'h8, 16'h8000, 32'h0, 8'h00);
    rd(`EPB_OD_POS, 8'h00, 64'h2100);
    rd(`EPB_OD_HRPOS, 8'h00, 64'h2100);
    $display("test scaling_preset done");
    wr(`EPB_OD_OPER, 8'h00, 32'h0000_0000, 1'b0);
    en = 8'($urandom);
    wr(`EPB_OD_CAMEN, 8'h01, {24'h0, en}, 1'b0);
    rd(`EPB_OD_CAMEN, 8'h01, {56'h0, en});
    for (int k = 0; k < 3; k++) begin
      c = 8'($urandom);
      sample(31'h0, 16'h0, sp_in[k], c);
      `TB_CHK(o_speed, sp_sat[k])
      `TB_CHK(o_cam_state, c & en)
      rd(`EPB_OD_SPEED, 8'h01, {48'h0, sp_sat[k]});
      rd(`EPB_OD_SPEED32, 8'h00, {32'h0, sp_in[k]});
      rd(`EPB_OD_ACCEL, 8'h01, 64'h8123);
      rd(`EPB_OD_CAMST, 8'h01, {56'h0, c & en});
    end
    rd(`EPB_OD_CAMST, 8'h00, 64'h1);
    $display("test speed_cam done");
    tick_gap(100 * CYC_MS);
    wr(`EPB_OD_TPDO1, `EPB_SUB_EVT, 32'h0000_0002, 1'b0);
    rd(`EPB_OD_CYC, 8'h00, 64'h2);
    rd(`EPB_OD_TPDO1, `EPB_SUB_EVT, 64'h2);
    rd(`EPB_OD_M_CYC, 8'h00, 64'h2);
    tick_gap(2 * CYC_MS);
    $display("test cyclic_timer done");
    repeat (4) @(posedge i_mclk);
    `TB_CHK(notes.size(), 0)
    stop_test();
  end

endmodule

// File: testbench/epb_master_model.sv
// Fieldbus master model that issues object dictionary requests.
`timescale 1ns/1ps

module epb_master_model
  import epb_pkg::*;
(
  input  wire logic i_mclk,
  output epb_req_t  o_req
);

  // ****************************************************************
  // Request driver
  // ****************************************************************
  initial o_req = '0;

  // One request per call, held for exactly the edge that takes it.
  // Released fields show their inverse so stale data cannot pass.
  task automatic access(input logic        wr,
                        input logic        rd,
                        input logic [15:0] idx,
                        input logic [7:0]  sub,
                        input logic [31:0] wd);
    @(posedge i_mclk);
    o_req <= '{wr: wr, rd: rd, index: idx, sub: sub, wdata: wd};
    @(posedge i_mclk);
    o_req <= '{wr: 1'b0, rd: 1'b0, index: ~idx, sub: ~sub, wdata: ~wd};
  endtask

endmodule
